// ===== logic/trig_count_pkg.sv
`default_nettype none
// ****************************************************************
// Shared constants and types for the trigger event counter
// ****************************************************************
package trig_count_pkg;

  // Register port, counter and pretrigger widths.
  localparam int ADDR_W = 20;
  localparam int DATA_W = 32;
  localparam int CNT_W = 48;
  localparam int PRE_W = 16;

  // Register offsets; the counter halves sit at the printed offset and the next one.
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 20'h00100;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 20'h00101;
  localparam logic [ADDR_W-1:0] PRE_ADDR = 20'h00102;
  localparam logic [ADDR_W-1:0] COUNT_LO_ADDR = 20'h310C9;
  localparam logic [ADDR_W-1:0] COUNT_HI_ADDR = 20'h310CA;

  // Control register fields; start, stop and the two trigger bits are pulses.
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_STOP_BIT = 1;
  localparam int CTRL_FIFO_BIT = 2;
  localparam int CTRL_STAMP_BIT = 3;
  localparam int CTRL_SEG_BIT = 4;
  localparam int CTRL_SWTRIG_BIT = 5;
  localparam int CTRL_FORCE_BIT = 6;

  // Status register fields.
  localparam int ST_RUN_BIT = 0;
  localparam int ST_SWREJ_BIT = 1;
  localparam int ST_FULL_BIT = 2;

  // Reset values and the value read at unmapped offsets.
  localparam logic [PRE_W-1:0] PRE_RESET = 16'h0004;
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 32'h0000_0000;

  // Acquisition states.
  typedef enum logic {
    ACQ_IDLE,
    ACQ_RUN
  } acq_e;

  // One timestamp record per trigger event.
  typedef struct packed {
    logic forced;
    logic [CNT_W-1:0] trigTime;
    logic [CNT_W-1:0] firstSample;
  } stamp_s;

  localparam int STAMP_W = $bits(stamp_s);

  // Complete state of the counter block.
  typedef struct packed {
    acq_e acq;
    logic run;
    logic fifoMode;
    logic stampEn;
    logic segmented;
    logic swRejected;
    logic [PRE_W-1:0] pretrig;
    logic [CNT_W-1:0] count;
    logic [CNT_W-DATA_W-1:0] countHi;
    logic [CNT_W-1:0] timeNow;
    logic [DATA_W-1:0] rdData;
  } ctl_state_s;

endpackage
`default_nettype wire

// ===== logic/stamp_buffer.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Small FIFO for timestamp records, all outputs registered
// ****************************************************************
module stamp_buffer #(
  parameter int WIDTH = 97,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Filling side
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  // Draining side
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [CW-1:0] cnt;
    logic [WIDTH-1:0] outData;
    logic outValid;
    logic inReady;
  } buf_state_s;

  buf_state_s bufReg;
  buf_state_s bufNext;
  logic push;
  logic pop;

  // Pointer advance with wrap at the depth.
  function automatic logic [PW-1:0] nextPtr(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // Outputs are recomputed from the next state, so they leave flip-flops directly.
  always_comb begin
    bufNext = bufReg;
    push = inValid && bufReg.inReady;
    pop = bufReg.outValid && outReady;
    if (push) begin
      bufNext.mem[bufReg.wr] = inData;
      bufNext.wr = nextPtr(bufReg.wr);
    end
    if (pop) begin
      bufNext.rd = nextPtr(bufReg.rd);
    end
    bufNext.cnt = bufReg.cnt + CW'(push) - CW'(pop);
    bufNext.outValid = (bufNext.cnt != '0);
    bufNext.inReady = (bufNext.cnt != CW'(DEPTH));
    bufNext.outData = bufNext.mem[bufNext.rd];
  end

  // State register; an empty buffer is ready to fill.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bufReg <= '0;
      bufReg.inReady <= 1'b1;
    end else begin
      bufReg <= bufNext;
    end
  end

  assign inReady = bufReg.inReady;
  assign outValid = bufReg.outValid;
  assign outData = bufReg.outData;

endmodule // stamp_buffer
`default_nettype wire

// ===== logic/trig_event_counter.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Trigger event counter with per-trigger timestamps
// ****************************************************************
// Overview of operation
// - Every accepted hardware trigger in segmented recording is counted; count stays readable during and after.
// - The trigger event counter is 48 bits wide.
// - Counting works in both standard and FIFO segmented modes.
// - With timestamps enabled each accepted trigger event produces one timestamp record.
// - Timestamp marks the trigger; first sample equals timestamp minus pretrigger.
// - Software trigger is refused while segmented recording is selected.
module trig_event_counter (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register port
  input wire logic [trig_count_pkg::ADDR_W-1:0] addr,
  input wire logic [trig_count_pkg::DATA_W-1:0] wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  output logic [trig_count_pkg::DATA_W-1:0] rdData,
  // Hardware trigger
  input wire logic hwTrig,
  output logic trigReady,
  // Timestamp stream
  output var trig_count_pkg::stamp_s stampData,
  output logic stampValid,
  input wire logic stampReady,
  // Acquisition state
  output logic running
);
  import trig_count_pkg::*;

  ctl_state_s stateReg;
  ctl_state_s stateNext;
  logic startCmd;
  logic stopCmd;
  logic swCmd;
  logic forceCmd;
  logic ctrlWr;
  logic preWr;
  logic isRun;
  logic swOk;
  logic trigEv;
  logic accept;
  logic countEv;
  logic bufReady;
  logic bufInValid;
  stamp_s bufInData;

  // Picks one pulse bit out of a control register write.
  function automatic logic ctrlFlag(input logic we, input logic [ADDR_W-1:0] a,
                                    input logic [DATA_W-1:0] d, input int pos);
    return we && (a == CTRL_ADDR) && d[pos];
  endfunction

  // ****************************************************************
  // Command decode and trigger qualification
  // ****************************************************************

  // Command pulses taken from control register writes.
  assign ctrlWr = wrEn && (addr == CTRL_ADDR);
  assign preWr = wrEn && (addr == PRE_ADDR);
  assign startCmd = ctrlFlag(wrEn, addr, wrData, CTRL_START_BIT);
  assign stopCmd = ctrlFlag(wrEn, addr, wrData, CTRL_STOP_BIT);
  assign swCmd = ctrlFlag(wrEn, addr, wrData, CTRL_SWTRIG_BIT);
  assign forceCmd = ctrlFlag(wrEn, addr, wrData, CTRL_FORCE_BIT);
  assign isRun = (stateReg.acq == ACQ_RUN);

  // A software trigger only acts outside segmented recording.
  assign swOk = swCmd && !stateReg.segmented;

  // A trigger that cannot be stamped is refused whole, so count and stamps agree.
  assign trigEv = isRun && (hwTrig || swOk || forceCmd);
  assign accept = trigEv && (!stateReg.stampEn || bufReady);

  // Forced triggers are stamped but never counted, so the host can tell them apart.
  assign countEv = accept && stateReg.segmented && hwTrig;

  // One record per accepted trigger while stamping is on.
  assign bufInValid = accept && stateReg.stampEn;

  // The stamp is the trigger time; the first stored sample lies pretrigger earlier.
  always_comb begin
    bufInData.forced = !hwTrig && !swOk;
    bufInData.trigTime = stateReg.timeNow;
    bufInData.firstSample = stateReg.timeNow - {{(CNT_W-PRE_W){1'b0}}, stateReg.pretrig};
  end

  // ****************************************************************
  // Next state
  // ****************************************************************

  // Acquisition control, counting and register access in one place.
  always_comb begin
    stateNext = stateReg;
    stateNext.rdData = '0;
    if (isRun) begin
      stateNext.timeNow = stateReg.timeNow + 48'h1;
    end
    // The counter wraps at its full width rather than saturating.
    if (countEv) begin
      stateNext.count = stateReg.count + 48'h1;
    end
    if (stopCmd) begin
      stateNext.acq = ACQ_IDLE;
      stateNext.run = 1'b0;
    end
    // Start wins over stop and over a trigger of the finishing run.
    if (startCmd) begin
      stateNext.acq = ACQ_RUN;
      stateNext.run = 1'b1;
      stateNext.count = '0;
      stateNext.timeNow = '0;
      stateNext.swRejected = 1'b0;
    end
    // The refusal flag is set after the start clear, so a refusal is never lost.
    if (swCmd && stateReg.segmented) begin
      stateNext.swRejected = 1'b1;
    end
    // Modes are frozen while running so one acquisition keeps one setup.
    if (ctrlWr && !isRun) begin
      stateNext.fifoMode = wrData[CTRL_FIFO_BIT];
      stateNext.stampEn = wrData[CTRL_STAMP_BIT];
      stateNext.segmented = wrData[CTRL_SEG_BIT];
    end
    if (preWr && !isRun) begin
      stateNext.pretrig = wrData[PRE_W-1:0];
    end
    if (rdEn) begin
      case (addr)
        CTRL_ADDR: begin
          stateNext.rdData[CTRL_FIFO_BIT] = stateReg.fifoMode;
          stateNext.rdData[CTRL_STAMP_BIT] = stateReg.stampEn;
          stateNext.rdData[CTRL_SEG_BIT] = stateReg.segmented;
        end
        STATUS_ADDR: begin
          stateNext.rdData[ST_RUN_BIT] = isRun;
          stateNext.rdData[ST_SWREJ_BIT] = stateReg.swRejected;
          stateNext.rdData[ST_FULL_BIT] = !bufReady;
        end
        PRE_ADDR: begin
          stateNext.rdData[PRE_W-1:0] = stateReg.pretrig;
        end
        // Reading the low half freezes the high half, keeping the pair coherent.
        COUNT_LO_ADDR: begin
          stateNext.rdData = stateReg.count[DATA_W-1:0];
          stateNext.countHi = stateReg.count[CNT_W-1:DATA_W];
        end
        COUNT_HI_ADDR: begin
          stateNext.rdData[CNT_W-DATA_W-1:0] = stateReg.countHi;
        end
        default: begin
          stateNext.rdData = UNMAPPED_READ;
        end
      endcase
    end
  end

  // State register.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stateReg <= '0;
      stateReg.acq <= ACQ_IDLE;
      stateReg.pretrig <= PRE_RESET;
    end else begin
      stateReg <= stateNext;
    end
  end

  assign rdData = stateReg.rdData;
  assign running = stateReg.run;

  // ****************************************************************
  // Timestamp buffer
  // ****************************************************************

  // Two records absorb a short receiver stall; beyond that triggers are held off.
  stamp_buffer #(
    .WIDTH(STAMP_W),
    .DEPTH(2)
  ) stampBuf (
    .ref_clk(ref_clk),
    .rst(rst),
    .inData(bufInData),
    .inValid(bufInValid),
    .inReady(bufReady),
    .outData(stampData),
    .outValid(stampValid),
    .outReady(stampReady)
  );

  assign trigReady = bufReady;

  // ****************************************************************
  // Checks
  // ****************************************************************

  a_start_clears_count: assert property (
    @(posedge ref_clk) disable iff (rst)
    startCmd |=> (stateReg.count == '0) && (stateReg.acq == ACQ_RUN))
    else $error("count not cleared at start");

  a_count_steps_one: assert property (
    @(posedge ref_clk) disable iff (rst)
    (countEv && !startCmd) |=> (stateReg.count == $past(stateReg.count) + 48'h1))
    else $error("counted trigger did not add one");

  a_count_holds_idle: assert property (
    @(posedge ref_clk) disable iff (rst)
    (!isRun && !startCmd) [*2] |-> $stable(stateReg.count))
    else $error("count moved while idle");

  a_count_wraps_full: assert property (
    @(posedge ref_clk) disable iff (rst)
    (countEv && !startCmd && (stateReg.count == 48'hFFFF_FFFF_FFFF))
      |=> (stateReg.count == '0))
    else $error("counter width not 48 bits");

  a_fifo_mode_counts: assert property (
    @(posedge ref_clk) disable iff (rst)
    (isRun && stateReg.segmented && stateReg.fifoMode && hwTrig && trigReady
      && !startCmd && !stopCmd) |=> (stateReg.count != $past(stateReg.count)))
    else $error("trigger not counted in FIFO mode");

  a_stamp_per_trigger: assert property (
    @(posedge ref_clk) disable iff (rst)
    (isRun && stateReg.stampEn && hwTrig && trigReady) |=> stampValid)
    else $error("trigger without timestamp record");

  a_stamp_marks_trigger: assert property (
    @(posedge ref_clk) disable iff (rst)
    bufInValid |-> (bufInData.trigTime == stateReg.timeNow)
      && (bufInData.trigTime - bufInData.firstSample == 48'(stateReg.pretrig)))
    else $error("timestamp not at trigger minus pretrigger");

  a_sw_trig_refused: assert property (
    @(posedge ref_clk) disable iff (rst)
    (swCmd && stateReg.segmented && !hwTrig && !forceCmd)
      |-> !countEv ##1 stateReg.swRejected)
    else $error("software trigger accepted in segmented mode");

  a_count_read_live: assert property (
    @(posedge ref_clk) disable iff (rst)
    (rdEn && (addr == COUNT_LO_ADDR)) |=> (rdData == $past(stateReg.count[DATA_W-1:0])))
    else $error("low count half not returned");

  a_high_half_frozen: assert property (
    @(posedge ref_clk) disable iff (rst)
    (rdEn && (addr == COUNT_LO_ADDR))
      |=> (stateReg.countHi == $past(stateReg.count[CNT_W-1:DATA_W])))
    else $error("high count half not frozen at low read");

  a_high_half_read: assert property (
    @(posedge ref_clk) disable iff (rst)
    (rdEn && (addr == COUNT_HI_ADDR))
      |=> (rdData == {{(2*DATA_W-CNT_W){1'b0}}, $past(stateReg.countHi)}))
    else $error("high count half read wrong");

  a_forced_not_counted: assert property (
    @(posedge ref_clk) disable iff (rst)
    (forceCmd && !hwTrig && !startCmd) |=> $stable(stateReg.count))
    else $error("forced trigger was counted");

  a_full_holds_off: assert property (
    @(posedge ref_clk) disable iff (rst)
    (isRun && stateReg.stampEn && hwTrig && !trigReady && !startCmd)
      |=> $stable(stateReg.count))
    else $error("trigger counted without room for its stamp");

  a_stamp_held: assert property (
    @(posedge ref_clk) disable iff (rst)
    (stampValid && !stampReady) |=> (stampValid && $stable(stampData)))
    else $error("waiting timestamp record changed");

  a_modes_frozen: assert property (
    @(posedge ref_clk) disable iff (rst)
    isRun |=> ($stable(stateReg.fifoMode) && $stable(stateReg.segmented)
      && $stable(stateReg.stampEn)))
    else $error("mode changed during acquisition");

  a_start_clears_refusal: assert property (
    @(posedge ref_clk) disable iff (rst)
    (startCmd && !(swCmd && stateReg.segmented)) |=> !stateReg.swRejected)
    else $error("refusal flag not cleared at start");

  a_time_from_start: assert property (
    @(posedge ref_clk) disable iff (rst)
    startCmd |=> (stateReg.timeNow == '0))
    else $error("trigger time not zeroed at start");

  a_time_advances: assert property (
    @(posedge ref_clk) disable iff (rst)
    (isRun && !startCmd) |=> (stateReg.timeNow == $past(stateReg.timeNow) + 48'h1))
    else $error("trigger time did not advance");

  a_stop_ends_run: assert property (
    @(posedge ref_clk) disable iff (rst)
    (stopCmd && !startCmd) |=> !running)
    else $error("acquisition still running after stop");

endmodule // trig_event_counter
`default_nettype wire

// ===== tb/stamp_sink.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Timestamp receiver that stalls on command
// ****************************************************************
module stamp_sink (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Mode: 0 prompt, 1 random stalls, 2 stalled
  input wire logic [1:0] mode,
  // Stream handshake
  output logic stampReady
);
  int seed = 32'he002;

  // Ready moves only after an edge, so a held record must wait in the buffer.
  always @(posedge ref_clk) begin
    if (rst) begin
      stampReady <= 1'b0;
    end else begin
      stampReady <= (mode == 2'h0) || (mode == 2'h1 && $random(seed) % 2 == 0);
    end
  end
endmodule // stamp_sink
`default_nettype wire

// ===== tb/trig_event_counter_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin failures++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
// ****************************************************************
// Self-checking bench against a behavioural count and stamp model
// ****************************************************************
module trig_event_counter_tb;
  import trig_count_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wrData = '0;
  logic wrEn = 1'b0;
  logic rdEn = 1'b0;
  logic hwTrig = 1'b0;
  logic [DATA_W-1:0] rdData;
  logic trigReady;
  logic stampValid;
  logic stampReady;
  logic running;
  stamp_s stampData;
  stamp_s got;
  logic [1:0] sinkMode = 2'h0;
  logic trigOn = 1'b0;
  int seed = 32'he002;
  int failures = 0;
  int samples_checked = 0;
  int k;
  int i;
  int pv;
  logic mRun;
  logic mStamp;
  logic mSeg;
  logic swRej;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] tnow;
  logic [15:0] hiFrz;
  logic [PRE_W-1:0] pre;
  logic [DATA_W-1:0] mRd;
  stamp_s expQ[$];
  logic room;
  logic frc;
  logic rej;
  int gap = 0;
  localparam int SEG_MIN = 8;

  always #2.5 ref_clk = ~ref_clk;

  trig_event_counter trig_event_counter_inst (.ref_clk(ref_clk), .rst(rst), .addr(addr),
    .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .hwTrig(hwTrig),
    .trigReady(trigReady), .stampData(stampData), .stampValid(stampValid),
    .stampReady(stampReady), .running(running));
  stamp_sink stamp_sink_inst (.ref_clk(ref_clk), .rst(rst), .mode(sinkMode),
    .stampReady(stampReady));

  // Model: sees the pre-edge inputs, so it updates exactly where the design does.
  always @(posedge ref_clk) begin
    if (rst) begin
      {mRun, mStamp, mSeg, swRej} = 4'h0;
      {cnt, tnow, hiFrz} = '0;
      pre = PRE_RESET;
      expQ.delete();
    end else begin
      // The queue holds exactly what the two-entry buffer holds before this edge.
      room = (expQ.size() < 2);
      `CHK(trigReady, room)
      if (rdEn) begin
        case (addr)
          STATUS_ADDR: mRd = {29'h0, expQ.size() >= 2, swRej, mRun};
          PRE_ADDR: mRd = {16'h0, pre};
          COUNT_LO_ADDR: begin
            mRd = cnt[31:0];
            hiFrz = cnt[47:32];
          end
          COUNT_HI_ADDR: mRd = {16'h0, hiFrz};
          default: mRd = UNMAPPED_READ;
        endcase
      end
      // Every record taken is checked here, so the queue size above is race free.
      if (stampValid === 1'b1 && stampReady === 1'b1) begin
        if (expQ.size() == 0) `CHK(stampValid, 1'b0)
        else begin
          got = expQ.pop_front();
          `CHK(stampData, got)
        end
      end
      // A real and a forced trigger in one cycle make one real record.
      frc = wrEn && addr == CTRL_ADDR && wrData[CTRL_FORCE_BIT];
      if ((hwTrig || frc) && mRun && (!mStamp || room)) begin
        if (mSeg && hwTrig) cnt = cnt + 1;
        if (mStamp) expQ.push_back('{!hwTrig, tnow, tnow - pre});
      end
      // The start cycle is time zero and the first edge after it stamps zero.
      tnow = tnow + 1;
      if (wrEn && addr == PRE_ADDR && !mRun) pre = wrData[15:0];
      if (wrEn && addr == CTRL_ADDR) begin
        rej = wrData[CTRL_SWTRIG_BIT] && mSeg;
        if (!mRun) {mStamp, mSeg} = {wrData[CTRL_STAMP_BIT], wrData[CTRL_SEG_BIT]};
        if (wrData[CTRL_START_BIT]) begin
          {mRun, swRej, cnt, tnow} = {2'b10, 96'h0};
        end else if (wrData[CTRL_STOP_BIT]) begin
          mRun = 1'b0;
        end
        if (rej) swRej = 1'b1;
      end
    end
  end

  // Running is checked once each edge has landed.
  always @(posedge ref_clk) begin
    #1;
    if (!rst) `CHK(running, mRun)
  end

  // Random one-cycle triggers kept one minimum segment apart, as the host's setup allows.
  always @(posedge ref_clk) begin
    gap <= hwTrig ? 0 : gap + 1;
    hwTrig <= trigOn && !hwTrig && (gap >= SEG_MIN - 2) && ($random(seed) % 3 == 0);
  end

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge ref_clk);
    wrEn <= 1'b1;
    addr <= a;
    wrData <= v;
    @(posedge ref_clk);
    wrEn <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge ref_clk);
    rdEn <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rdEn <= 1'b0;
    #1;
    `CHK(rdData, mRd)
  endtask

  task automatic conclude();
    $display("checked %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // A wait that used up its bound is a failure and ends the run.
  task automatic expire(input int n, input int lim);
    if (n >= lim) begin
      failures++;
      conclude();
    end
  endtask

  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    rd(STATUS_ADDR);
    rd(PRE_ADDR);
    rd(COUNT_LO_ADDR);
    rd(COUNT_HI_ADDR);
    rd(20'h00200);
    `CHK(trigReady, 1'b1)
    $display("test 1 done");
    pv = (($random(seed) & 255) % 255 + 1) * 4;
    wr(PRE_ADDR, pv);
    rd(PRE_ADDR);
    sinkMode <= 2'h1;
    trigOn <= 1'b1;
    wr(CTRL_ADDR, 32'h0000_0019);
    for (k = 0; k < 40; k++) begin
      repeat ($random(seed) & 7) @(posedge ref_clk);
      rd(COUNT_LO_ADDR);
      rd(COUNT_HI_ADDR);
    end
    $display("test 2 done");
    trigOn <= 1'b0;
    wr(CTRL_ADDR, 32'h0000_0020);
    rd(STATUS_ADDR);
    for (i = 0; i < 60 && trigReady !== 1'b1; i++) @(posedge ref_clk);
    expire(i, 60);
    wr(CTRL_ADDR, 32'h0000_0040);
    rd(COUNT_LO_ADDR);
    $display("test 3 done");
    sinkMode <= 2'h2;
    trigOn <= 1'b1;
    for (i = 0; i < 60 && trigReady !== 1'b0; i++) @(posedge ref_clk);
    expire(i, 60);
    rd(STATUS_ADDR);
    `CHK(expQ.size(), 2)
    sinkMode <= 2'h0;
    for (i = 0; i < 60 && expQ.size() != 0; i++) @(posedge ref_clk);
    expire(i, 60);
    $display("test 4 done");
    wr(CTRL_ADDR, 32'h0000_0002);
    repeat (20) @(posedge ref_clk);
    rd(COUNT_LO_ADDR);
    rd(COUNT_HI_ADDR);
    $display("test 5 done");
    wr(CTRL_ADDR, 32'h0000_0015);
    rd(COUNT_LO_ADDR);
    for (k = 0; k < 20; k++) begin
      repeat ($random(seed) & 7) @(posedge ref_clk);
      rd(COUNT_LO_ADDR);
    end
    wr(CTRL_ADDR, 32'h0000_0002);
    rd(COUNT_LO_ADDR);
    $display("test 6 done");
    conclude();
  end
endmodule // trig_event_counter_tb
`default_nettype wire
